//--- common/synth_ctrl_pkg.sv
// Package with constants and carrier types for the parallel load synthesiser control.
package synth_ctrl_pkg;

    // =====================================================================
    // Word layouts
    // =====================================================================
    localparam int WORD_W = 16;
    localparam int SWALLOW_LSB = 0;
    localparam int SWALLOW_W = 3;
    localparam int MAIN_LSB = 3;
    localparam int MAIN_W = 11;
    localparam int GAIN_LSB = 14;
    localparam int GAIN_W = 2;
    localparam int REF_LSB = 0;
    localparam int REF_W = 10;
    localparam int PD_ENABLE_BIT = 11;
    localparam int PD_SENSE_BIT = 12;

    // =====================================================================
    // Reset values and counts
    // =====================================================================
    localparam logic [15:0] RF_WORD_RESET = 16'hffff;
    localparam logic [15:0] REF_WORD_RESET = 16'hffff;
    localparam int PRESCALE_LOW = 8;
    localparam int PRESCALE_HIGH = 9;
    localparam logic [3:0] PRESCALE_LOW_LAST = 4'h7;
    localparam logic [3:0] PRESCALE_HIGH_LAST = 4'h8;

    // =====================================================================
    // Carrier types
    // =====================================================================
    typedef struct packed {
        logic [1:0] gain;
        logic [10:0] main_count;
        logic [2:0] swallow_count;
    } rf_word_s;

    typedef struct packed {
        logic [2:0] spare;
        logic pd_sense;
        logic pd_enable;
        logic spare_bit;
        logic [9:0] ref_count;
    } ref_word_s;

    typedef struct packed {
        logic pump_up;
        logic pump_down;
        logic pump_enable;
    } pump_s;

endpackage

//--- design/parallel_load_synth_divider_ctrl.sv
// Parallel programming port, dividers and phase detector control of the synthesiser.
`timescale 1ns/1ps
// Notes on behaviour
// R1: Full programming takes two 16-bit words: RF divider word and reference word.
// R2: Writing only the RF word keeps the stored reference settings.
// R3: Address high (or floating) selects the RF divider buffer.
// R4: Address low selects the reference divider buffer.
// R5: Floating data bus inputs read as one.
// R6: Selected buffer follows the bus while strobe high, holds while low.
// R7: Data is captured at strobe fall; host keeps address and data stable.
// R8: Strobe high (or floating) holds counters in reset and disables pump.
// R9: Strobe low loads counters and control, runs counters, enables pump; the pump is enabled only when reference bit 11 is also set.
// R10: Reference bit 12 set and RF phase leading makes the pump sink.
// R11: RF divider output pulse lasts eight RF input cycles.
// R12: Reference output pulse lasts one reference input high period.
// R13: Lock indicator sink is on whenever lock detect reports lock.
// R14: RF ratio is main times modulus plus swallow.
// R15: Prescaler divides by nine while swallowing, then eight; both reload together.
module parallel_load_synth_divider_ctrl (
    // Clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // Host programming port; open pins are modelled by the pad as ones
    input wire logic [15:0] data_bus_in,
    input wire logic address_in,
    input wire logic strobe_in,
    // Divider inputs, one enable per input cycle
    input wire logic rf_cycle_in,
    input wire logic ref_cycle_in,
    input wire logic ref_high_in,
    // Lock detect
    input wire logic lock_report_in,
    // Outputs
    output logic rf_divided_pulse_out,
    output logic ref_divided_pulse_out,
    output logic pump_sink_out,
    output logic pump_source_out,
    output logic pump_enable_out,
    output logic lock_sink_out,
    output logic [1:0] gain_out
);

    // =====================================================================
    // Programming buffers
    // =====================================================================
    // R5 unwritten bits read one
    synth_ctrl_pkg::rf_word_s rf_buf_reg;
    synth_ctrl_pkg::ref_word_s ref_buf_reg;

    // R6 transparent buffers
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            rf_buf_reg <= synth_ctrl_pkg::RF_WORD_RESET;
        end else if (strobe_in && address_in) begin
            // R3 RF buffer select
            rf_buf_reg <= data_bus_in;
        end
    end

    // R2 reference kept
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            ref_buf_reg <= synth_ctrl_pkg::REF_WORD_RESET;
        end else if (strobe_in && !address_in) begin
            // R4 reference buffer select
            ref_buf_reg <= data_bus_in;
        end
    end

    // R7 last sample before the strobe falls is what is held.
    // R1 two words form the full setting.
    logic run;
    assign run = !strobe_in;

    // =====================================================================
    // Control register loaded while running
    // =====================================================================
    logic [1:0] gain_reg;
    logic pd_sense_reg;
    logic pd_enable_reg;

    // R9 control register load
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            gain_reg <= 2'h0;
            pd_sense_reg <= 1'b0;
            pd_enable_reg <= 1'b0;
        end else if (run) begin
            gain_reg <= rf_buf_reg.gain;
            pd_sense_reg <= ref_buf_reg.pd_sense;
            pd_enable_reg <= ref_buf_reg.pd_enable;
        end
    end
    assign gain_out = gain_reg;

    // =====================================================================
    // RF divider: dual modulus prescaler with swallow and main counters
    // =====================================================================
    logic [3:0] pre_reg;
    logic [2:0] swallow_reg;
    logic [10:0] main_reg;
    logic [2:0] pulse_cnt_reg;
    logic rf_pulse_reg;
    logic pre_last;
    logic swallowing;

    assign swallowing = (swallow_reg != 3'h0);
    assign pre_last = swallowing ? (pre_reg == synth_ctrl_pkg::PRESCALE_HIGH_LAST)
                                 : (pre_reg == synth_ctrl_pkg::PRESCALE_LOW_LAST);

    // R14 ratio main times eight plus swallow
    always_ff @(posedge clock_in) begin
        if (sys_rst_in || !run) begin
            // R8 counters held in reset
            pre_reg <= 4'h0;
            swallow_reg <= rf_buf_reg.swallow_count;
            main_reg <= rf_buf_reg.main_count;
        end else if (rf_cycle_in) begin
            if (pre_last) begin
                pre_reg <= 4'h0;
                // R15 reload both at cycle end
                if (main_reg <= 11'h1) begin
                    swallow_reg <= rf_buf_reg.swallow_count;
                    main_reg <= rf_buf_reg.main_count;
                end else begin
                    main_reg <= main_reg - 11'h1;
                    if (swallowing) begin
                        swallow_reg <= swallow_reg - 3'h1;
                    end
                end
            end else begin
                pre_reg <= pre_reg + 4'h1;
            end
        end
    end

    // R11 eight cycle output pulse
    always_ff @(posedge clock_in) begin
        if (sys_rst_in || !run) begin
            rf_pulse_reg <= 1'b0;
            pulse_cnt_reg <= 3'h0;
        end else if (rf_cycle_in) begin
            if (pre_last && main_reg <= 11'h1) begin
                rf_pulse_reg <= 1'b1;
                pulse_cnt_reg <= 3'h0;
            end else if (rf_pulse_reg) begin
                pulse_cnt_reg <= pulse_cnt_reg + 3'h1;
                if (pulse_cnt_reg == 3'h7) begin
                    rf_pulse_reg <= 1'b0;
                end
            end
        end
    end
    assign rf_divided_pulse_out = rf_pulse_reg;

    // =====================================================================
    // Reference divider
    // =====================================================================
    logic [9:0] ref_cnt_reg;
    logic ref_hit_reg;
    logic ref_pulse_reg;
    logic ref_wrap;

    // A ratio of zero wraps on every input cycle, so it divides by one.
    assign ref_wrap = (ref_cnt_reg + 10'h1 >= ref_buf_reg.ref_count);

    always_ff @(posedge clock_in) begin
        if (sys_rst_in || !run) begin
            ref_cnt_reg <= 10'h0;
            ref_hit_reg <= 1'b0;
        end else if (ref_cycle_in) begin
            if (ref_wrap) begin
                ref_cnt_reg <= 10'h0;
                ref_hit_reg <= 1'b1;
            end else begin
                ref_cnt_reg <= ref_cnt_reg + 10'h1;
                ref_hit_reg <= 1'b0;
            end
        end
    end

    // R12 pulse spans one high period
    always_ff @(posedge clock_in) begin
        if (sys_rst_in || !run) begin
            ref_pulse_reg <= 1'b0;
        end else begin
            // The hit flag is not yet set in the wrapping cycle, so the wrap itself opens the pulse.
            ref_pulse_reg <= ref_high_in && (ref_cycle_in ? ref_wrap : ref_hit_reg);
        end
    end
    assign ref_divided_pulse_out = ref_pulse_reg;

    // =====================================================================
    // Phase detector and charge pump
    // =====================================================================
    logic rf_seen_reg;
    logic ref_seen_reg;
    logic rf_rise;
    logic ref_rise;
    logic rf_prev_reg;
    logic ref_prev_reg;
    synth_ctrl_pkg::pump_s pump_reg;

    assign rf_rise = rf_pulse_reg && !rf_prev_reg;
    assign ref_rise = ref_pulse_reg && !ref_prev_reg;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in || !run) begin
            rf_prev_reg <= 1'b0;
            ref_prev_reg <= 1'b0;
            rf_seen_reg <= 1'b0;
            ref_seen_reg <= 1'b0;
        end else begin
            rf_prev_reg <= rf_pulse_reg;
            ref_prev_reg <= ref_pulse_reg;
            if ((rf_seen_reg || rf_rise) && (ref_seen_reg || ref_rise)) begin
                rf_seen_reg <= 1'b0;
                ref_seen_reg <= 1'b0;
            end else begin
                rf_seen_reg <= rf_seen_reg || rf_rise;
                ref_seen_reg <= ref_seen_reg || ref_rise;
            end
        end
    end

    // R10 sense selects sink direction
    always_ff @(posedge clock_in) begin
        if (sys_rst_in || !run) begin
            pump_reg <= '0;
        end else begin
            pump_reg.pump_enable <= pd_enable_reg;
            pump_reg.pump_down <= 1'b0;
            pump_reg.pump_up <= 1'b0;
            if (rf_seen_reg != ref_seen_reg) begin
                pump_reg.pump_down <= (rf_seen_reg == pd_sense_reg);
                pump_reg.pump_up <= (rf_seen_reg != pd_sense_reg);
            end
        end
    end

    // R9 pump enabled when running and reference bit 11 set
    assign pump_enable_out = pump_reg.pump_enable && run;
    assign pump_sink_out = pump_reg.pump_down && pump_enable_out;
    assign pump_source_out = pump_reg.pump_up && pump_enable_out;

    // =====================================================================
    // Lock indicator
    // =====================================================================
    logic lock_reg;

    // R13 lock sink follows detect
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            lock_reg <= 1'b0;
        end else begin
            lock_reg <= lock_report_in;
        end
    end
    assign lock_sink_out = lock_reg;

endmodule

//--- dv/synth_ctrl_asserts.sv
// Assertion checker for the synthesiser control ports.
`timescale 1ns/1ps
module synth_ctrl_asserts (
    // Clock, reset and inputs
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic strobe_in,
    input wire logic rf_cycle_in,
    input wire logic ref_high_in,
    input wire logic lock_report_in,
    // Watched outputs
    input wire logic rf_divided_pulse_out,
    input wire logic ref_divided_pulse_out,
    input wire logic pump_sink_out,
    input wire logic pump_source_out,
    input wire logic pump_enable_out,
    input wire logic lock_sink_out,
    input wire logic [1:0] gain_out
);
    // ==========
    // Port relations
    // ==========
    default clocking @(posedge clock_in);
    endclocking
    default disable iff (sys_rst_in);
    a_pump_off_held: assert property (strobe_in |-> !pump_enable_out)
        else $error("pump on in hold");
    a_pump_dir_gated: assert property (pump_sink_out || pump_source_out |-> pump_enable_out)
        else $error("pump drives while off");
    a_lock_one_cycle: assert property (!$past(sys_rst_in) |-> lock_sink_out == $past(lock_report_in))
        else $error("lock sink wrong");
    a_gain_frozen: assert property (!strobe_in [*4] |-> $stable(gain_out))
        else $error("gain moved");
    a_enable_frozen: assert property (!strobe_in [*4] |-> $stable(pump_enable_out))
        else $error("pump enable moved");
    a_rf_held_low: assert property (strobe_in [*3] |-> !rf_divided_pulse_out)
        else $error("rf pulse in hold");
    a_ref_held_low: assert property (strobe_in [*3] |-> !ref_divided_pulse_out)
        else $error("ref pulse in hold");
    a_rf_on_enable: assert property ($changed(rf_divided_pulse_out) |->
        $past(rf_cycle_in) || $past(strobe_in) || $past(sys_rst_in))
        else $error("rf pulse moved alone");
    a_ref_in_high: assert property (ref_divided_pulse_out |-> $past(ref_high_in))
        else $error("ref pulse outside input high");
endmodule

bind parallel_load_synth_divider_ctrl synth_ctrl_asserts synth_ctrl_asserts_i (.clock_in, .sys_rst_in,
    .strobe_in, .rf_cycle_in, .ref_high_in, .lock_report_in, .rf_divided_pulse_out, .ref_divided_pulse_out,
    .pump_sink_out, .pump_source_out, .pump_enable_out, .lock_sink_out, .gain_out);

//--- dv/host_port_model.sv
// Host controller model that writes words over the parallel port.
`timescale 1ns/1ps
module host_port_model (
    // Clock
    input wire logic clock_in,
    // Programming port
    output logic [15:0] data_bus_out,
    output logic address_out,
    output logic strobe_out
);
    // Open pins idle high, so the strobe starts high.
    initial begin
        data_bus_out = 16'hffff;
        address_out = 1'h1;
        strobe_out = 1'h1;
    end
    // One word per strobe pulse, held across its fall.
    task automatic write_word(input logic addr, input logic [15:0] word);
        @(negedge clock_in);
        address_out = addr;
        data_bus_out = word;
        strobe_out = 1'h1;
        repeat (24) @(negedge clock_in);
        strobe_out = 1'h0;
        repeat (2) @(negedge clock_in);
        data_bus_out = ~word;
        address_out = ~addr;
    endtask
endmodule

//--- dv/test_parallel_load_synth_divider_ctrl.sv
// Self-checking bench for the synthesiser control block.
`timescale 1ns/1ps
module test_parallel_load_synth_divider_ctrl;
    logic clock_in, sys_rst_in, rf_cycle_in, ref_cycle_in, ref_high_in, lock_report_in;
    logic address, strobe, rf_p, ref_p, sink, source, pump_en, lock_sink, fast, exp_en;
    logic [15:0] data_bus, w;
    logic [1:0] gain, exp_gain;
    logic [31:0] seed;
    int fails, checks_done, cycles, ph, rf_ratio, sink_n, src_n;
    int ref_hist[$];

    host_port_model host_port_model_i (.clock_in, .data_bus_out(data_bus), .address_out(address),
        .strobe_out(strobe));
    parallel_load_synth_divider_ctrl parallel_load_synth_divider_ctrl_i (.clock_in, .sys_rst_in,
        .data_bus_in(data_bus), .address_in(address), .strobe_in(strobe), .rf_cycle_in, .ref_cycle_in,
        .ref_high_in, .lock_report_in, .rf_divided_pulse_out(rf_p), .ref_divided_pulse_out(ref_p),
        .pump_sink_out(sink), .pump_source_out(source), .pump_enable_out(pump_en),
        .lock_sink_out(lock_sink), .gain_out(gain));

    // ==========
    // Clock, stimulus and checks
    // ==========
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    initial begin
        clock_in = 1'h0;
        forever #2.5 clock_in = ~clock_in;
    end

    // The reference input runs at a quarter of the clock.
    always @(negedge clock_in) begin
        rf_cycle_in <= fast || rnd() % 2 == 1;
        ref_high_in <= ph < 2;
        ref_cycle_in <= ph == 0;
        lock_report_in <= rnd() % 3 == 0;
        ph <= (ph + 1) % 4;
        sink_n += sink;
        src_n += source;
    end

    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check_out(input logic [1:0] got, input logic [1:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic check_count(input int got, input int exp, input string what);
        checks_done++;
        if (got != exp) begin
            fails++;
            $display("BAD %0t %s got %0d exp %0d", $time, what, got, exp);
        end
    endtask

    // Writes one word and updates the bench model.
    task automatic put(input logic addr, input logic [15:0] word);
        host_port_model_i.write_word(addr, word);
        if (addr) begin
            rf_ratio = word[13:3] * 8 + word[2:0];
            exp_gain = word[15:14];
        end else begin
            ref_hist.push_back(word[9:0] == 0 ? 1 : word[9:0]);
            exp_en = word[11];
        end
    endtask

    // Counts input enables over the second full output period.
    task automatic measure(input logic side, output int period, output int width);
        int k;
        logic p, e, last;
        k = 0;
        period = 0;
        width = 0;
        last = 1'h1;
        for (int n = 0; n < 4000 && k < 3; n++) begin
            @(posedge clock_in);
            #1;
            p = side ? ref_p : rf_p;
            e = side ? ref_cycle_in : rf_cycle_in;
            k += p && !last;
            last = p;
            if (k == 2) begin
                period += e;
                width += p && (side || e);
            end
        end
        check_count(k, 3, "pulses seen");
    endtask

    task automatic verify();
        int per, wid;
        repeat (4) @(posedge clock_in);
        #1;
        check_out(gain, exp_gain, "gain");
        check_out({1'h0, lock_sink}, {1'h0, lock_report_in}, "lock sink");
        check_out({1'h0, pump_en}, {1'h0, exp_en}, "pump enable");
        measure(1'h0, per, wid);
        check_count(per, rf_ratio, "rf period");
        check_count(wid, 8, "rf width");
        measure(1'h1, per, wid);
        check_count(per, ref_hist[$], "ref period");
        check_count(wid, 2, "ref width");
    endtask

    initial begin
        seed = 32'h79bf;
        fast = 1'h0;
        sys_rst_in = 1'h1;
        rf_cycle_in = 1'h0;
        ref_cycle_in = 1'h0;
        ref_high_in = 1'h0;
        lock_report_in = 1'h0;
        repeat (5) @(posedge clock_in);
        @(negedge clock_in);
        sys_rst_in = 1'h0;
        repeat (3) @(posedge clock_in);
        #1;
        check_out({1'h0, pump_en}, 2'h0, "pump in hold");
        w = 16'(rnd());
        put(1'h0, {w[15:12], 1'h1, w[10], 6'h0, 4'h5});
        put(1'h1, {w[15:14], 7'h0, 1'h1, w[5:0]});
        verify();
        for (int i = 0; i < 3; i++) begin
            w = 16'(rnd());
            put(1'h1, {w[15:14], 7'h0, 1'h1, w[5:0]});
            verify();
            w = 16'(rnd());
            put(1'h0, {w[15:12], 1'(i != 1), w[10], 6'h0, 4'(rnd() % 6)});
            verify();
        end
        fast = 1'h1;
        put(1'h1, 16'h0009);
        for (int s = 0; s < 2; s++) begin
            put(1'h0, {3'h0, 1'(s), 12'h803});
            repeat (40) @(posedge clock_in);
            sink_n = 0;
            src_n = 0;
            repeat (300) @(posedge clock_in);
            check_count(sink_n > src_n, s, "pump direction");
        end
        tally_and_finish();
    end
endmodule
